/* File: rtl/sli_irq_flags.sv */
// Purpose: Link interrupt enable and status registers with configuration mismatch check.
// Assumes: Link events and alignment data come from logic on clock_i.
// Notes: Status bits clear by writing one; a same-cycle event wins.
`timescale 1ns/1ps
`include "sli_params.svh"
module sli_irq_flags #(
    parameter int LANES  = 8,
    parameter int LANE_W = 3
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic [11:0]       reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic [7:0]        link_evt_i,
    input  wire logic [7:0]        irq_en_a_i,
    input  wire logic              ilas_valid_i,
    input  wire logic [LANE_W-1:0] ilas_lane_i,
    input  wire sli_pkg::sli_cfg_t ilas_cfg_i,
    output logic                   irq_o
);
    // Refuses a lane count that the lane number cannot address.
    if (LANES < 1 || LANES > (1 << LANE_W)) begin : g_bad_lanes
        $error("LANES does not fit LANE_W.");
    end

    sli_pkg::sli_cfg_t prog_cfg_r;
    logic [7:0]        en_b_r;
    logic [7:0]        stat_a_r;
    logic [7:0]        stat_b_r;
    logic [7:0]        stat_a_nxt;
    logic [7:0]        stat_b_nxt;
    logic [7:0]        rdata_nxt;

    sli_cmp_if cmp_if ();
    sli_cfg_compare u_cmp (
        .cmp_if (cmp_if.cmp)
    );
    assign cmp_if.rx_cfg   = ilas_cfg_i;
    assign cmp_if.prog_cfg = prog_cfg_r;

    wire        sel_en_b = (reg_addr_i == `SLI_OFS_EN_B);
    wire        sel_st_a = (reg_addr_i == `SLI_OFS_STAT_A);
    wire        sel_st_b = (reg_addr_i == `SLI_OFS_STAT_B);
    wire        sel_cfg  = (reg_addr_i >= `SLI_OFS_CFG_FIRST) &&
                           (reg_addr_i <= `SLI_OFS_CFG_LAST);
    wire [11:0] cfg_ofs  = reg_addr_i - `SLI_OFS_CFG_FIRST;
    wire [3:0]  cfg_idx  = cfg_ofs[3:0];

    // Mismatch is judged on lane 0 only.
    wire lane0_ilas = ilas_valid_i && (ilas_lane_i == '0);
    wire set_mism   = lane0_ilas && cmp_if.cfg_diff;
    wire set_cks    = ilas_valid_i && cmp_if.cks_good;

    wire [7:0] set_a  = {link_evt_i[7:3], set_cks, link_evt_i[1:0]};
    wire [7:0] clr_a  = (reg_wr_i && sel_st_a) ? reg_wdata_i : 8'h00;
    wire [7:0] clr_b  = (reg_wr_i && sel_st_b) ? {7'h00, reg_wdata_i[0]} : 8'h00;
    wire [7:0] set_b  = {7'h00, set_mism};

    assign stat_a_nxt = (stat_a_r & ~clr_a) | set_a;
    assign stat_b_nxt = (stat_b_r & ~clr_b) | set_b;

    assign rdata_nxt = sel_en_b ? en_b_r :
                       sel_st_a ? stat_a_r :
                       sel_st_b ? stat_b_r :
                       sel_cfg  ? prog_cfg_r[cfg_idx] :
                       8'h00;

    // Enables share bit positions with the flags.
    wire irq_nxt = |(stat_a_r & irq_en_a_i) | |(stat_b_r & en_b_r);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stat_a_r <= `SLI_RST_STAT_A;
            stat_b_r <= `SLI_RST_STAT_B;
            irq_o    <= 1'b0;
        end else begin
            stat_a_r <= stat_a_nxt;
            stat_b_r <= stat_b_nxt;
            irq_o    <= irq_nxt;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            en_b_r      <= `SLI_RST_EN_B;
            reg_rdata_o <= `SLI_RST_RDATA;
        end else begin
            if (reg_wr_i && sel_en_b) begin
                en_b_r <= {7'h00, reg_wdata_i[0]};
            end
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `SLI_CFG_BYTES; i++) begin
                prog_cfg_r[i] <= `SLI_RST_CFG;
            end
        end else if (reg_wr_i && sel_cfg) begin
            prog_cfg_r[cfg_idx] <= reg_wdata_i;
        end
    end

    property p_lane0_only;
        @(posedge clock_i) disable iff (rst_i)
        $rose(stat_b_r[`SLI_BIT_MISMATCH]) |-> $past(lane0_ilas);
    endproperty
    a_lane0_only: assert property (p_lane0_only)
        else $error("Mismatch set without lane 0 data.");

    property p_cmp_prog;
        @(posedge clock_i) disable iff (rst_i)
        (ilas_valid_i && ilas_lane_i == '0 && ilas_cfg_i != prog_cfg_r)
            |=> stat_b_r[`SLI_BIT_MISMATCH];
    endproperty
    a_cmp_prog: assert property (p_cmp_prog)
        else $error("Differing config not flagged.");

    property p_mism_hold;
        @(posedge clock_i) disable iff (rst_i)
        (stat_b_r[`SLI_BIT_MISMATCH] && !(reg_wr_i && sel_st_b && reg_wdata_i[0]))
            |=> stat_b_r[`SLI_BIT_MISMATCH];
    endproperty
    a_mism_hold: assert property (p_mism_hold)
        else $error("Mismatch flag lost.");

    property p_cks_byte;
        @(posedge clock_i) disable iff (rst_i)
        (lane0_ilas && ilas_cfg_i[`SLI_CKS_IDX] != prog_cfg_r[`SLI_CKS_IDX])
            |=> stat_b_r[`SLI_BIT_MISMATCH];
    endproperty
    a_cks_byte: assert property (p_cks_byte)
        else $error("Checksum difference not flagged.");

    property p_evt_flags;
        @(posedge clock_i) disable iff (rst_i)
        (link_evt_i[`SLI_BIT_DISP] || link_evt_i[`SLI_BIT_CG_SYNC])
            |=> (stat_a_r[`SLI_BIT_DISP] || !$past(link_evt_i[`SLI_BIT_DISP]))
                && (stat_a_r[`SLI_BIT_CG_SYNC] || !$past(link_evt_i[`SLI_BIT_CG_SYNC]));
    endproperty
    a_evt_flags: assert property (p_evt_flags)
        else $error("Link event not latched.");

    property p_cks_set;
        @(posedge clock_i) disable iff (rst_i)
        (ilas_valid_i && cmp_if.cks_good) |=> stat_a_r[`SLI_BIT_GOOD_CKS];
    endproperty
    a_cks_set: assert property (p_cks_set)
        else $error("Good checksum not flagged.");

    property p_cks_src;
        @(posedge clock_i) disable iff (rst_i)
        $rose(stat_a_r[`SLI_BIT_GOOD_CKS]) |-> $past(set_cks);
    endproperty
    a_cks_src: assert property (p_cks_src)
        else $error("Checksum flag from wrong source.");

    property p_irq;
        @(posedge clock_i) disable iff (rst_i)
        ((|(stat_a_r & irq_en_a_i)) || (stat_b_r[0] && en_b_r[0])) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt not raised.");

    property p_irq_low;
        @(posedge clock_i) disable iff (rst_i)
        !((|(stat_a_r & irq_en_a_i))
          || (stat_b_r[`SLI_BIT_MISMATCH] && en_b_r[`SLI_BIT_MISMATCH]))
            |=> !irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("Interrupt raised without an enabled flag.");

    // A written one clears a flag unless its event repeats in that cycle.
    property p_set_wins;
        @(posedge clock_i) disable iff (rst_i)
        (link_evt_i[`SLI_BIT_DISP] && reg_wr_i && sel_st_a)
            |=> stat_a_r[`SLI_BIT_DISP];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Clear beat a same-cycle event.");

    property p_clr_a;
        @(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && sel_st_a && reg_wdata_i[`SLI_BIT_LANE_SYNC]
         && !link_evt_i[`SLI_BIT_LANE_SYNC])
            |=> !stat_a_r[`SLI_BIT_LANE_SYNC];
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("Lane sync flag not cleared.");

    property p_fs_set;
        @(posedge clock_i) disable iff (rst_i)
        link_evt_i[`SLI_BIT_FRAME_SYNC] |=> stat_a_r[`SLI_BIT_FRAME_SYNC];
    endproperty
    a_fs_set: assert property (p_fs_set)
        else $error("Frame sync event not latched.");

    property p_mism_lane;
        @(posedge clock_i) disable iff (rst_i)
        (!stat_b_r[`SLI_BIT_MISMATCH] && !(ilas_valid_i && ilas_lane_i == '0))
            |=> !stat_b_r[`SLI_BIT_MISMATCH];
    endproperty
    a_mism_lane: assert property (p_mism_lane)
        else $error("Mismatch set by another lane.");

    property p_cfg_write;
        @(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == `SLI_OFS_CFG_LAST)
            |=> (prog_cfg_r[`SLI_CKS_IDX] == $past(reg_wdata_i));
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("Programmed checksum byte not stored.");

    // The programmed checksum byte never holds back the good checksum flag.
    property p_cks_prog;
        @(posedge clock_i) disable iff (rst_i)
        (ilas_valid_i && cmp_if.cks_good
         && ilas_cfg_i[`SLI_CKS_IDX] != prog_cfg_r[`SLI_CKS_IDX])
            |=> stat_a_r[`SLI_BIT_GOOD_CKS];
    endproperty
    a_cks_prog: assert property (p_cks_prog)
        else $error("Programmed checksum blocked the good checksum flag.");

    property p_cks_idle;
        @(posedge clock_i) disable iff (rst_i)
        (!ilas_valid_i && !stat_a_r[`SLI_BIT_GOOD_CKS])
            |=> !stat_a_r[`SLI_BIT_GOOD_CKS];
    endproperty
    a_cks_idle: assert property (p_cks_idle)
        else $error("Good checksum flag set without alignment data.");
endmodule : sli_irq_flags

/* File: rtl/sli_params.svh */
// Purpose: Offsets, bit positions, reset values and sizes of the link interrupt flag block.
// Assumes: Register addresses are the 12-bit internal addresses of the configuration port.
// Notes: Definitions only.
// Functional notes
// - Configuration mismatch is checked on lane 0 only; other lanes never affect it.
// - Received alignment configuration is compared against programmed bytes 0x450 to 0x45D.
// - Any differing compared value sets bit 0 of the second status register.
// - Every alignment byte is compared, checksum included; checksum difference alone suffices.
// - First status register bits 7..0 hold disparity through code group sync flags.
// - Good checksum compares transmitted checksum with checksum computed from received data.
// - Good checksum ignores the programmed checksum byte at 0x45D entirely.
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH

`define SLI_OFS_EN_B      12'h4B9
`define SLI_OFS_STAT_A    12'h4BA
`define SLI_OFS_STAT_B    12'h4BB
`define SLI_OFS_CFG_FIRST 12'h450
`define SLI_OFS_CFG_LAST  12'h45D

`define SLI_CFG_BYTES     14
`define SLI_CKS_IDX       13

`define SLI_BIT_DISP       7
`define SLI_BIT_NOT_TBL    6
`define SLI_BIT_UNEXP_K    5
`define SLI_BIT_DESKEW     4
`define SLI_BIT_LANE_SYNC  3
`define SLI_BIT_GOOD_CKS   2
`define SLI_BIT_FRAME_SYNC 1
`define SLI_BIT_CG_SYNC    0
`define SLI_BIT_MISMATCH   0

`define SLI_RST_EN_B      8'h00
`define SLI_RST_STAT_A    8'h00
`define SLI_RST_STAT_B    8'h00
`define SLI_RST_CFG       8'h00
`define SLI_RST_RDATA     8'h00

`endif

/* File: rtl/sli_pkg.sv */
// Purpose: Types shared by the link interrupt flag block.
// Assumes: sli_params.svh gives the configuration byte count.
// Notes: Byte 13 of a configuration is the checksum.
`include "sli_params.svh"
package sli_pkg;
    typedef logic [7:0] sli_byte_t;
    typedef sli_byte_t [`SLI_CFG_BYTES-1:0] sli_cfg_t;
endpackage : sli_pkg

/* File: rtl/sli_cmp_if.sv */
// Purpose: Carries configurations to the comparator and its verdicts back.
// Assumes: Pure combinational use.
// Notes: None.
`timescale 1ns/1ps
interface sli_cmp_if;
    sli_pkg::sli_cfg_t rx_cfg;
    sli_pkg::sli_cfg_t prog_cfg;
    logic              cfg_diff;
    logic              cks_good;
    modport src (output rx_cfg, output prog_cfg, input cfg_diff, input cks_good);
    modport cmp (input rx_cfg, input prog_cfg, output cfg_diff, output cks_good);
endinterface : sli_cmp_if

/* File: rtl/sli_cfg_compare.sv */
// Purpose: Compares received and programmed alignment data and checks the received checksum.
// Assumes: Checksum is the modulo-256 sum of bytes 0 to 12.
// Notes: Combinational.
`timescale 1ns/1ps
`include "sli_params.svh"
module sli_cfg_compare (
    sli_cmp_if.cmp cmp_if
);
    logic [7:0] sum;

    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < `SLI_CKS_IDX; i++) begin
            sum = sum + cmp_if.rx_cfg[i];
        end
    end

    // Only transmitted bytes feed the checksum check.
    assign cmp_if.cks_good = (sum == cmp_if.rx_cfg[`SLI_CKS_IDX]);
    // All bytes, checksum included, take part.
    assign cmp_if.cfg_diff = (cmp_if.rx_cfg != cmp_if.prog_cfg);
endmodule : sli_cfg_compare

/* File: rtl/sli_unused.sv */
// Purpose: Reserved for block-level helpers; it holds no logic.
// Assumes: Nothing.
// Notes: The block is built from the other files alone.

/* File: tb/sli_tx_model.sv */
// Purpose: Transmitter side of the link that feeds events and alignment data.
// Assumes: Driven 1 ns after the rising edge.
// Notes: Released alignment lines show the inverse of the last value.
`timescale 1ns/1ps
module sli_tx_model (
    input  wire logic         clock_i,
    output logic [7:0]        link_evt_o,
    output logic              ilas_valid_o,
    output logic [2:0]        ilas_lane_o,
    output sli_pkg::sli_cfg_t ilas_cfg_o
);
    initial begin
        link_evt_o = 8'h00;
        ilas_valid_o = 1'b0;
        ilas_lane_o = 3'h7;
        ilas_cfg_o = '0;
    end

    task automatic send_cfg(input logic [2:0] lane, input sli_pkg::sli_cfg_t cfg);
        ilas_lane_o = lane;
        ilas_cfg_o = cfg;
        ilas_valid_o = 1'b1;
        @(posedge clock_i);
        #1;
        ilas_valid_o = 1'b0;
        ilas_lane_o = ~lane;
        ilas_cfg_o = ~cfg;
        @(posedge clock_i);
        #1;
    endtask : send_cfg

    task automatic pulse_evt(input logic [7:0] bits);
        link_evt_o = bits;
        @(posedge clock_i);
        #1;
        link_evt_o = 8'h00;
        @(posedge clock_i);
        #1;
    endtask : pulse_evt
endmodule : sli_tx_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the link interrupt flag block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Each scenario is its own task.
`timescale 1ns/1ps
module tb_top;
    logic              clock_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [11:0]       reg_addr_i = 12'h000;
    logic              reg_wr_i = 1'b0;
    logic              reg_rd_i = 1'b0;
    logic [7:0]        reg_wdata_i = 8'h00;
    logic [7:0]        irq_en_a_i = 8'h00;
    logic [7:0]        reg_rdata_o, link_evt_i;
    logic              ilas_valid_i, irq_o;
    logic [2:0]        ilas_lane_i;
    sli_pkg::sli_cfg_t ilas_cfg_i, good_cfg, bad_cfg;
    int                mismatches = 0;
    int                n_compared = 0;

    always #5 clock_i = ~clock_i;

    sli_irq_flags #(.LANES(8), .LANE_W(3)) uut (.clock_i(clock_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .link_evt_i(link_evt_i),
        .irq_en_a_i(irq_en_a_i), .ilas_valid_i(ilas_valid_i), .ilas_lane_i(ilas_lane_i),
        .ilas_cfg_i(ilas_cfg_i), .irq_o(irq_o));
    sli_tx_model tx (.clock_i(clock_i), .link_evt_o(link_evt_i), .ilas_valid_o(ilas_valid_i),
        .ilas_lane_o(ilas_lane_i), .ilas_cfg_o(ilas_cfg_i));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_op(input logic wr, input logic [11:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = wr;
        reg_rd_i = !wr;
        @(posedge clock_i);
        #1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        @(posedge clock_i);
        #1;
    endtask : reg_op

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        reg_op(1'b0, a, 8'h00);
        check(reg_rdata_o, exp);
    endtask : rd

    task automatic t_regs;
        rd(12'h4B9, 8'h00);
        rd(12'h4BA, 8'h00);
        rd(12'h4BB, 8'h00);
        rd(12'h123, 8'h00);
        reg_op(1'b1, 12'h4B9, 8'hFF);
        rd(12'h4B9, 8'h01);
        for (int i = 0; i < 14; i++) reg_op(1'b1, 12'(12'h450 + i), good_cfg[i]);
        rd(12'h45D, 8'h5B);
    endtask : t_regs

    task automatic t_ilas;
        tx.send_cfg(3'h0, good_cfg);
        rd(12'h4BB, 8'h00);
        rd(12'h4BA, 8'h04);
        reg_op(1'b1, 12'h4BA, 8'h04);
        tx.send_cfg(3'h0, bad_cfg);
        rd(12'h4BB, 8'h01);
        check({7'h00, irq_o}, 8'h01);
        rd(12'h4BA, 8'h00);
        reg_op(1'b1, 12'h4BB, 8'h01);
        tx.send_cfg(3'h5, bad_cfg);
        rd(12'h4BB, 8'h00);
        check({7'h00, irq_o}, 8'h00);
        reg_op(1'b1, 12'h45D, 8'h00);
        tx.send_cfg(3'h0, good_cfg);
        rd(12'h4BB, 8'h01);
        rd(12'h4BA, 8'h04);
        reg_op(1'b1, 12'h4BA, 8'h04);
        reg_op(1'b1, 12'h4BB, 8'h01);
    endtask : t_ilas

    task automatic t_events;
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            tx.pulse_evt(b);
            rd(12'h4BA, (i == 2) ? 8'h00 : b);
            irq_en_a_i = b;
            @(posedge clock_i);
            #1;
            @(posedge clock_i);
            #1;
            check({7'h00, irq_o}, (i == 2) ? 8'h00 : 8'h01);
            irq_en_a_i = 8'h00;
            reg_op(1'b1, 12'h4BA, b);
            rd(12'h4BA, 8'h00);
        end
    endtask : t_events

    task automatic t_misc;
        tx.send_cfg(3'h3, good_cfg);
        rd(12'h4BB, 8'h00);
        rd(12'h4BA, 8'h04);
        reg_op(1'b1, 12'h4BA, 8'hFB);
        rd(12'h4BA, 8'h04);
        tx.pulse_evt(8'h80);
        fork
            tx.pulse_evt(8'h80);
            reg_op(1'b1, 12'h4BA, 8'h80);
        join
        rd(12'h4BA, 8'h84);
        irq_en_a_i = 8'h80;
        @(posedge clock_i);
        #1;
        @(posedge clock_i);
        #1;
        check({7'h00, irq_o}, 8'h01);
        rst_i = 1'b1;
        @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        check({7'h00, irq_o}, 8'h00);
        check(reg_rdata_o, 8'h00);
        rd(12'h4BA, 8'h00);
        rd(12'h4B9, 8'h00);
        rd(12'h450, 8'h00);
        tx.send_cfg(3'h0, good_cfg);
        rd(12'h4BB, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        irq_en_a_i = 8'h00;
    endtask : t_misc

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        for (int i = 0; i < 13; i++) good_cfg[i] = 8'(i + 1);
        good_cfg[13] = 8'h5B;
        bad_cfg = good_cfg;
        bad_cfg[13] = 8'h5C;
        repeat (4) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        t_regs();
        t_ilas();
        t_events();
        t_misc();
        end_sim();
    end

    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
endmodule : tb_top
